// ==== hw/afpmc_pkg.sv ====
/*
 * constants and types shared by both ends of the frame-select converter link
 * assumes a 25 MHz system clock at each end; the link pins are sampled by it
 */
package afpmc_pkg;

    // ----------------------------------------------------------------
    // frame layout
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int LEAD_ZEROS = 4;
    localparam int DATA_BITS = FRAME_BITS - LEAD_ZEROS;
    localparam int RES_BITS_DEF = 12;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // ----------------------------------------------------------------
    // falling-edge counts that steer the power state
    // ----------------------------------------------------------------
    localparam logic [4:0] PD_MIN_EDGE = 5'h02;
    localparam logic [4:0] KEEP_EDGE = 5'h0A;
    localparam logic [4:0] TRACK_EDGE = 5'h0D;
    localparam logic [4:0] LAST_EDGE = 5'h0F;
    localparam logic [4:0] FULL_EDGE = 5'h10;
    localparam logic [4:0] CNT_RST = 5'h00;

    // ----------------------------------------------------------------
    // times and derived cycle counts
    // ----------------------------------------------------------------
    localparam int CLK_NS = 40;
    localparam int PWRUP_NS = 1000;
    localparam int PWRUP_CYC = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int QUIET_NS = 60;
    localparam int QUIET_CYC = (QUIET_NS + CLK_NS - 1) / CLK_NS;
    localparam int DIS_NS = 35;
    localparam int DIS_CYC = (DIS_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_LAG = 3;
    localparam int QWAIT_CYC = SYNC_LAG + DIS_CYC + QUIET_CYC;
    localparam int SCLK_HALF_DEF = 4;
    localparam logic [7:0] TMR_RST = 8'h00;

    // ----------------------------------------------------------------
    // power modes and host sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_PWRUP = 2'b01,
        MODE_PDOWN = 2'b10
    } afpmc_mode_e;

    localparam afpmc_mode_e MODE_RST = MODE_NORMAL;
    localparam logic TRACK_RST = 1'b1;

    typedef enum logic [2:0] {
        HST_IDLE = 3'b000,
        HST_SETUP = 3'b001,
        HST_CLOCK = 3'b010,
        HST_HOLD = 3'b011,
        HST_QUIET = 3'b100
    } afpmc_hst_e;

endpackage

// ==== hw/afpmc_if.sv ====
/*
 * link between host and converter: frame select, serial clock, result line
 * assumes the result line is pulled low while nobody drives it
 */
`timescale 1ns/1ps
interface afpmc_if;
    logic cs_n;
    logic sclk;
    logic serial_result_out;
    logic serial_result_oe;
    logic serial_result_line;

    // resolved wire level, low when released
    assign serial_result_line = serial_result_oe ? serial_result_out : 1'b0;

    modport dev (
        input cs_n,
        input sclk,
        output serial_result_out,
        output serial_result_oe
    );

    modport host (
        output cs_n,
        output sclk,
        input serial_result_line
    );
endinterface // afpmc_if

// ==== hw/afpmc_dev.sv ====
/*
 * converter end: frame decode, result shifter, power mode and track-and-hold
 * assumes cs_n and sclk come from another clock and the host keeps sclk
 * half periods of at least four system clocks
 */
`timescale 1ns/1ps
module afpmc_dev
    import afpmc_pkg::*;
#(
    parameter int RES_BITS = RES_BITS_DEF,
    parameter afpmc_mode_e START_MODE = MODE_RST
) (
    input wire logic CLK,
    input wire logic RST_B,
    afpmc_if.dev LINK,
    input wire logic [RES_BITS-1:0] SAMPLE,
    output logic [1:0] MODE,
    output logic ANALOG_ON,
    output logic PWR_READY,
    output logic TRACK,
    output logic CONV_START
);

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    localparam int PU_W = $clog2(PWRUP_CYC + 1);
    localparam int PAD = DATA_BITS - RES_BITS;
    localparam logic [PU_W-1:0] PU_DONE = PU_W'(PWRUP_CYC);
    localparam logic [PU_W-1:0] PU_RST = '0;

    generate
        if (RES_BITS < 1 || RES_BITS > DATA_BITS) begin : g_bad_res
            $error("result width does not fit the data field");
        end
    endgenerate

    // ----------------------------------------------------------------
    // pin synchronisers and edge detect
    // ----------------------------------------------------------------
    logic [2:0] cs_sync_q;
    logic [2:0] sclk_sync_q;
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic sclk_rise;

    // stage 0 feeds stage 1 only; stage 2 is the previous stage 1
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cs_sync_q <= 3'h7;
            sclk_sync_q <= 3'h7;
        end else begin
            cs_sync_q <= {cs_sync_q[1:0], LINK.cs_n};
            sclk_sync_q <= {sclk_sync_q[1:0], LINK.sclk};
        end
    end

    assign cs_fall = !cs_sync_q[1] && cs_sync_q[2];
    assign cs_rise = cs_sync_q[1] && !cs_sync_q[2];
    assign sclk_fall = !sclk_sync_q[1] && sclk_sync_q[2];
    assign sclk_rise = sclk_sync_q[1] && !sclk_sync_q[2];

    // ----------------------------------------------------------------
    // frame tracking and falling-edge count
    // ----------------------------------------------------------------
    logic frame_q;
    logic [4:0] cnt_q;
    logic last_fall;

    assign last_fall = frame_q && sclk_fall && (cnt_q == LAST_EDGE);

    // count restarts on every frame fall, ends at the sixteenth fall
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            frame_q <= 1'b0;
            cnt_q <= CNT_RST;
        end else if (cs_fall) begin
            frame_q <= 1'b1;
            cnt_q <= CNT_RST;
        end else if (cs_rise) begin
            frame_q <= 1'b0;
        end else if (frame_q && sclk_fall) begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == LAST_EDGE) begin
                frame_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // result shifter and line drive
    // ----------------------------------------------------------------
    logic [DATA_BITS-1:0] res_pad;
    logic [15:0] shift_q;
    logic sdo_q;
    logic oe_q;

    // narrower results get trailing zeros
    assign res_pad = DATA_BITS'(SAMPLE) << PAD;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            shift_q <= WORD_RST;
            sdo_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (cs_fall) begin
            shift_q <= {{LEAD_ZEROS{1'b0}}, res_pad};
            sdo_q <= 1'b0; // first leading zero
            oe_q <= 1'b1;
        end else if (cs_rise) begin
            oe_q <= 1'b0;
        end else if (frame_q && sclk_fall) begin
            if (cnt_q == LAST_EDGE) begin
                oe_q <= 1'b0;
            end else begin
                shift_q <= {shift_q[14:0], 1'b0};
                sdo_q <= shift_q[14];
            end
        end
    end

    assign LINK.serial_result_out = sdo_q;
    assign LINK.serial_result_oe = oe_q;

    // ----------------------------------------------------------------
    // power mode
    // ----------------------------------------------------------------
    afpmc_mode_e mode_q;

    // decided by the fall count at the frame select rise or sixteenth fall; wakes from power-down at the frame select fall
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            mode_q <= START_MODE;
        end else if (cs_fall) begin
            if (mode_q == MODE_PDOWN) begin
                mode_q <= MODE_PWRUP;
            end
        end else if (cs_rise && frame_q) begin
            case (mode_q)
                MODE_NORMAL: begin
                    if (cnt_q >= PD_MIN_EDGE && cnt_q < KEEP_EDGE) begin
                        mode_q <= MODE_PDOWN;
                    end // else
                end
                MODE_PWRUP: begin
                    if (cnt_q < KEEP_EDGE) begin
                        mode_q <= MODE_PDOWN;
                    end else begin
                        mode_q <= MODE_NORMAL;
                    end
                end
                default: mode_q <= mode_q;
            endcase
        end else if (last_fall && mode_q == MODE_PWRUP) begin
            mode_q <= MODE_NORMAL;
        end
    end

    assign MODE = mode_q;
    assign ANALOG_ON = (mode_q != MODE_PDOWN);

    // ----------------------------------------------------------------
    // power-up timer
    // ----------------------------------------------------------------
    logic [PU_W-1:0] pu_cnt_q;

    // analog core counts as settled one microsecond after power-on
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pu_cnt_q <= PU_RST;
        end else if (mode_q == MODE_PDOWN) begin
            pu_cnt_q <= PU_RST;
        end else if (pu_cnt_q != PU_DONE) begin
            pu_cnt_q <= pu_cnt_q + PU_W'(1);
        end
    end

    assign PWR_READY = (pu_cnt_q == PU_DONE);

    // ----------------------------------------------------------------
    // track-and-hold
    // ----------------------------------------------------------------
    logic track_q;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            track_q <= TRACK_RST;
        end else if (cs_fall) begin
            track_q <= 1'b0;
        end else if (cs_rise && frame_q) begin
            // stays in hold when the rise sends the part down
            if (mode_q == MODE_PWRUP) begin
                track_q <= (cnt_q >= KEEP_EDGE);
            end else if (mode_q == MODE_NORMAL) begin
                track_q <= !(cnt_q >= PD_MIN_EDGE && cnt_q < KEEP_EDGE);
            end
        end else if (frame_q && mode_q == MODE_PWRUP && cnt_q == CNT_RST
                     && (sclk_fall || sclk_rise)) begin
            track_q <= 1'b1;
        end else if (frame_q && mode_q == MODE_NORMAL && sclk_rise
                     && cnt_q >= TRACK_EDGE) begin
            track_q <= 1'b1; // acquire next sample
        end
    end

    assign TRACK = track_q;

    // ----------------------------------------------------------------
    // conversion start strobe
    // ----------------------------------------------------------------
    logic conv_start_q;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            conv_start_q <= 1'b0;
        end else begin
            conv_start_q <= cs_fall;
        end
    end

    assign CONV_START = conv_start_q;

endmodule // afpmc_dev

// ==== hw/afpmc_host.sv ====
/*
 * host end: drives frame select and a divided serial clock, shifts in the
 * result word and keeps the quiet interval before the next frame
 * assumes the converter end runs from its own clock of the same rate
 */
`timescale 1ns/1ps
module afpmc_host
    import afpmc_pkg::*;
#(
    parameter int SCLK_HALF = SCLK_HALF_DEF
) (
    input wire logic CLK,
    input wire logic RST_B,
    afpmc_if.host LINK,
    input wire logic START,
    input wire logic [4:0] EDGES,
    output logic BUSY,
    output logic DONE,
    output logic [15:0] DATA
);

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    localparam logic [7:0] HALF_M1 = 8'(SCLK_HALF - 1);
    localparam logic [7:0] QWAIT_M1 = 8'(QWAIT_CYC - 1);

    generate
        if (SCLK_HALF < 4 || SCLK_HALF > 255) begin : g_bad_half
            $error("serial clock half period out of range");
        end
    endgenerate

    // ----------------------------------------------------------------
    // result line synchroniser
    // ----------------------------------------------------------------
    logic [1:0] sd_sync_q;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sd_sync_q <= 2'h0;
        end else begin
            sd_sync_q <= {sd_sync_q[0], LINK.serial_result_line};
        end
    end

    // ----------------------------------------------------------------
    // frame sequencer
    // ----------------------------------------------------------------
    afpmc_hst_e st_q;
    logic [7:0] tmr_q;
    logic [4:0] fcnt_q;
    logic [4:0] edges_q;
    logic cs_n_q;
    logic sclk_q;
    logic done_q;
    logic [15:0] data_q;
    logic tmr_zero;

    assign tmr_zero = (tmr_q == TMR_RST);

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_q <= HST_IDLE;
            tmr_q <= TMR_RST;
            fcnt_q <= CNT_RST;
            edges_q <= CNT_RST;
            cs_n_q <= 1'b1;
            sclk_q <= 1'b1;
            done_q <= 1'b0;
            data_q <= WORD_RST;
        end else begin
            done_q <= 1'b0;
            if (!tmr_zero) begin
                tmr_q <= tmr_q - 8'h01;
            end
            case (st_q)
                HST_IDLE: begin
                    // edge counts of zero or above sixteen are ignored
                    if (START && EDGES != CNT_RST && EDGES <= FULL_EDGE) begin
                        edges_q <= EDGES;
                        cs_n_q <= 1'b0;
                        tmr_q <= HALF_M1;
                        fcnt_q <= CNT_RST;
                        st_q <= HST_SETUP;
                    end
                end
                HST_SETUP: begin
                    if (tmr_zero) begin
                        sclk_q <= 1'b0;
                        fcnt_q <= fcnt_q + 5'h01;
                        // fresh word: a short frame leaves no bits of the last one
                        data_q <= {15'h0000, sd_sync_q[1]};
                        tmr_q <= HALF_M1;
                        st_q <= HST_CLOCK;
                    end
                end
                HST_CLOCK: begin
                    if (tmr_zero) begin
                        tmr_q <= HALF_M1;
                        if (!sclk_q) begin
                            sclk_q <= 1'b1;
                            if (fcnt_q == edges_q) begin
                                st_q <= HST_HOLD;
                            end
                        end else begin
                            sclk_q <= 1'b0;
                            fcnt_q <= fcnt_q + 5'h01;
                            data_q <= {data_q[14:0], sd_sync_q[1]};
                        end
                    end
                end
                HST_HOLD: begin
                    if (tmr_zero) begin
                        cs_n_q <= 1'b1;
                        tmr_q <= QWAIT_M1;
                        st_q <= HST_QUIET;
                    end
                end
                HST_QUIET: begin
                    if (tmr_zero) begin
                        done_q <= 1'b1;
                        st_q <= HST_IDLE;
                    end
                end
                default: st_q <= HST_IDLE;
            endcase
        end
    end

    assign LINK.cs_n = cs_n_q;
    assign LINK.sclk = sclk_q;
    assign BUSY = (st_q != HST_IDLE);
    assign DONE = done_q;
    assign DATA = data_q;

endmodule // afpmc_host

// ==== tb/afpmc_properties.sv ====
/*
 * concurrent checks on the link between host end and converter end
 * assumes the bench top hands over the link signals, CLK and RST_B of one interface
 */
`timescale 1ns/1ps
module afpmc_properties
    import afpmc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_result_out,
    input wire logic serial_result_oe,
    input wire logic serial_result_line
);
    logic sclk_q;
    logic [4:0] fall_cnt_q;
    logic full_seen;
    logic sclk_fell;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    // ----------------------------------------------------------------
    // helper: falling serial clock edges inside the frame
    // ----------------------------------------------------------------
    // previous serial clock level, idles high
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sclk_q <= 1'b1;
        end else begin
            sclk_q <= sclk;
        end
    end

    // count cleared while frame select is high, saturates
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            fall_cnt_q <= CNT_RST;
        end else if (cs_n) begin
            fall_cnt_q <= CNT_RST;
        end else if (sclk_q && !sclk && fall_cnt_q != 5'h1F) begin
            fall_cnt_q <= fall_cnt_q + 5'h01;
        end
    end

    assign full_seen = (fall_cnt_q == FULL_EDGE);
    assign sclk_fell = sclk_q && !sclk;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_idle_release: assert property (cs_n [*4] |-> !serial_result_oe)
        else $error("result line driven while frame select idles");
    a_frame_drive: assert property ($fell(cs_n) |-> ##[1:5] serial_result_oe)
        else $error("result line not driven after frame start");
    a_lead_zeros: assert property (
        !cs_n && serial_result_oe && fall_cnt_q < 5'(LEAD_ZEROS) |-> !serial_result_line)
        else $error("leading bit of the word is not zero");
    a_full_release: assert property ($rose(full_seen) |-> ##[1:5] !serial_result_oe)
        else $error("result line still driven after the last bit");
    a_drive_hold: assert property (
        !cs_n && serial_result_oe && fall_cnt_q < FULL_EDGE |=> serial_result_oe)
        else $error("result line released inside the frame");
    a_sclk_idle: assert property (cs_n |-> sclk)
        else $error("serial clock not high outside the frame");
    a_half_period: assert property ($changed(sclk) |=> $stable(sclk) [*3])
        else $error("serial clock half period too short");
    a_quiet_gap: assert property ($rose(cs_n) |-> cs_n [*6])
        else $error("next frame started inside the quiet interval");
    a_bit_timing: assert property (
        serial_result_oe && $past(serial_result_oe) && $changed(serial_result_out)
        |-> $past(sclk_fell, 3))
        else $error("result bit changed without a serial clock fall");

    // ----------------------------------------------------------------
    // covers for the main kinds of frame
    // ----------------------------------------------------------------
    c_full_frame: cover property ($rose(full_seen));
    c_power_down: cover property ($rose(cs_n) && fall_cnt_q >= PD_MIN_EDGE
        && fall_cnt_q < KEEP_EDGE);
    c_glitch: cover property ($rose(cs_n) && fall_cnt_q < PD_MIN_EDGE);
endmodule // afpmc_properties

// ==== tb/test_adc_frame_power_mode_control.sv ====
/*
 * bench for the host end and converter end joined by one link, plus a second
 * converter end driven directly with stray serial clocks outside any frame
 * assumes the design package, interface and both ends are compiled first
 */
`timescale 1ns/1ps
module test_adc_frame_power_mode_control
    import afpmc_pkg::*;
;
    logic CLK = 1'b0;
    logic RST_B = 1'b0;
    logic start = 1'b0;
    logic [4:0] edges = 5'h01;
    logic [RES_BITS_DEF-1:0] sample = 12'h000;
    logic [1:0] mode;
    logic [1:0] mode_b;
    logic analog_on;
    logic pwr_ready;
    logic track;
    logic conv_start;
    logic busy;
    logic done;
    logic [15:0] data;
    int miscompares = 0;
    int cmp_count = 0;
    int starts = 0;
    // frame lengths in falling edges, and which frames end in power-down
    localparam logic [4:0] N_TAB [11] = '{5'h10, 5'h01, 5'h0A, 5'h0F, 5'h02, 5'h01,
        5'h09, 5'h0A, 5'h09, 5'h10, 5'h10};
    localparam logic [10:0] DOWN_TAB = 11'h170;

    afpmc_if link();
    afpmc_if link_b();

    // ----------------------------------------------------------------
    // design ends and checker
    // ----------------------------------------------------------------
    afpmc_dev afpmc_dev_inst (.CLK(CLK), .RST_B(RST_B), .LINK(link.dev), .SAMPLE(sample),
        .MODE(mode), .ANALOG_ON(analog_on), .PWR_READY(pwr_ready), .TRACK(track),
        .CONV_START(conv_start));
    afpmc_host afpmc_host_inst (.CLK(CLK), .RST_B(RST_B), .LINK(link.host), .START(start),
        .EDGES(edges), .BUSY(busy), .DONE(done), .DATA(data));
    afpmc_dev afpmc_dev_inst_b (.CLK(CLK), .RST_B(RST_B), .LINK(link_b.dev), .SAMPLE(sample),
        .MODE(mode_b), .ANALOG_ON(), .PWR_READY(), .TRACK(), .CONV_START());
    afpmc_properties afpmc_properties_inst (.CLK(CLK), .RST_B(RST_B), .cs_n(link.cs_n),
        .sclk(link.sclk), .serial_result_out(link.serial_result_out),
        .serial_result_oe(link.serial_result_oe),
        .serial_result_line(link.serial_result_line));

    // ----------------------------------------------------------------
    // clock, start counter, compare and verdict
    // ----------------------------------------------------------------
    always #20 CLK = ~CLK;

    // one pulse per frame start on the first pair
    always @(posedge CLK) begin
        if (conv_start === 1'b1) begin
            starts++;
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // one host frame of n falling edges, then the state it leaves behind
    task automatic run_frame(input logic [4:0] n, input logic down, input logic [11:0] smp);
        logic [15:0] word;
        logic got;
        word = {4'h0, smp};
        got = 1'b0;
        @(negedge CLK);
        sample = smp;
        edges = n;
        start = 1'b1;
        @(negedge CLK);
        start = 1'b0;
        check("busy", 16'(busy), 16'h0001);
        for (int i = 0; i < 600 && !got; i++) begin
            @(posedge CLK);
            #1;
            got = (done === 1'b1);
        end
        check("done", 16'(got), 16'h0001);
        check("busy end", 16'(busy), 16'h0000);
        check("data", data, word >> (16 - int'(n)));
        check("mode", 16'(mode), down ? 16'(MODE_PDOWN) : 16'(MODE_NORMAL));
        check("analog_on", 16'(analog_on), 16'(!down));
        check("pwr_ready", 16'(pwr_ready), 16'(!down));
        if (down) begin
            check("track", 16'(track), 16'h0000);
        end else if (n >= KEEP_EDGE) begin
            check("track", 16'(track), 16'h0001);
        end
    endtask

    // one serial clock half period on the second link
    task automatic b_half(input logic lvl);
        @(negedge CLK);
        link_b.sclk = lvl;
        repeat (3) @(negedge CLK);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        link_b.cs_n = 1'b1;
        link_b.sclk = 1'b1;
        repeat (20) @(negedge CLK);
        RST_B = 1'b1;
        @(negedge CLK);
        check("reset mode", 16'(mode), 16'(MODE_NORMAL));
        check("reset track", 16'(track), 16'h0001);
        check("reset analog", 16'(analog_on), 16'h0001);
        // normal, glitch, abort, power-down, failed and good power-up
        for (int i = 0; i < 11; i++) begin
            run_frame(N_TAB[i], DOWN_TAB[i], 12'hA5C + 12'(i) * 12'h3B1);
        end
        check("starts", 16'(starts), 16'h000B);
        // stray clocks with frame select high must be ignored
        for (int i = 0; i < 8; i++) begin
            b_half(1'b0);
            b_half(1'b1);
        end
        check("stray oe", 16'(link_b.serial_result_oe), 16'h0000);
        check("stray mode", 16'(mode_b), 16'(MODE_NORMAL));
        // three falls then release puts the second end down
        @(negedge CLK);
        link_b.cs_n = 1'b0;
        repeat (3) @(negedge CLK);
        for (int i = 0; i < 3; i++) begin
            b_half(1'b0);
            b_half(1'b1);
        end
        link_b.cs_n = 1'b1;
        repeat (8) @(negedge CLK);
        check("b mode", 16'(mode_b), 16'(MODE_PDOWN));
        check("b oe", 16'(link_b.serial_result_oe), 16'h0000);
        give_verdict();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge CLK);
        miscompares++;
        give_verdict();
    end
endmodule // test_adc_frame_power_mode_control
